// ### mse_params.svh
`ifndef MSE_PARAMS_SVH
`define MSE_PARAMS_SVH

// special register selector codes
`define MSE_SEL_APPLICATION_STATUS_REG       4'h0
`define MSE_SEL_IPSR       4'h1
`define MSE_SEL_EPSR       4'h2
`define MSE_SEL_IEPSR      4'h3
`define MSE_SEL_IAPSR      4'h4
`define MSE_SEL_EAPSR      4'h5
`define MSE_SEL_PSR        4'h6
`define MSE_SEL_MSP        4'h7
`define MSE_SEL_PSP        4'h8
`define MSE_SEL_PRIMSK     4'h9
`define MSE_SEL_FLOOR      4'ha
`define MSE_SEL_FLOOR_CA   4'hb
`define MSE_SEL_FAULTMSK   4'hc
`define MSE_SEL_CONTROL    4'hd

// status word field positions
`define MSE_FLAGS_HI       31
`define MSE_FLAGS_LO       27
`define MSE_EXEC_MASK      32'h0700fc00
`define MSE_IPSR_MASK      32'h000001ff
`define MSE_APPLICATION_STATUS_REG_MASK      32'hf8000000

// reset value and field widths
`define MSE_PSR_RST        32'h01000000
`define MSE_FLOOR_W        8
`define MSE_CTRL_W         2

`endif

// ### mse_pkg.sv
package mse_pkg;

    typedef enum logic [3:0] {
        MSE_OP_NONE  = 4'h0,
        MSE_OP_BREAKPOINT_INSTR  = 4'h1,
        MSE_OP_CPS   = 4'h2,
        MSE_OP_DMB   = 4'h3,
        MSE_OP_DSB   = 4'h4,
        MSE_OP_ISB   = 4'h5,
        MSE_OP_MRS   = 4'h6,
        MSE_OP_MSR   = 4'h7,
        MSE_OP_NOP   = 4'h8,
        MSE_OP_SEV   = 4'h9,
        MSE_OP_SVC   = 4'ha,
        MSE_OP_WFE   = 4'hb,
        MSE_OP_WFI   = 4'hc
    } mse_op_e;

    typedef enum logic [1:0] {
        MSE_ST_RUN   = 2'b00,
        MSE_ST_DRAIN = 2'b01,
        MSE_ST_SLEEP = 2'b10
    } mse_state_e;

endpackage : mse_pkg

// ### mse_sync.sv
`timescale 1ns/1ns
`default_nettype none

// three-stage synchroniser; output changes once stages two and three agree
module mse_sync (
    // clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // data
    input  wire logic din,
    output var  logic dout
);

    logic [2:0] sh_ff;
    logic [2:0] nxt_sh;
    logic       out_ff;
    logic       nxt_out;

    always_comb begin
        nxt_sh  = {sh_ff[1:0], din};
        nxt_out = (sh_ff[1] == sh_ff[2]) ? sh_ff[2] : out_ff;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sh_ff  <= 3'h0;
            out_ff <= 1'b0;
        end else begin
            sh_ff  <= nxt_sh;
            out_ff <= nxt_out;
        end
    end

    assign dout = out_ff;

endmodule : mse_sync

`default_nettype wire

// ### mse_floor_upd.sv
`timescale 1ns/1ns
`default_nettype none

`include "mse_params.svh"

// conditional priority-floor update for the alias write
module mse_floor_upd #(
    parameter int W = `MSE_FLOOR_W
) (
    // operands
    input  wire logic [W-1:0] cur,
    input  wire logic [W-1:0] src,
    // result
    output var  logic         take
);

    always_comb begin
        take = (src != '0) && ((cur == '0) || (src < cur));
    end

endmodule : mse_floor_upd

`default_nettype wire

// ### mse_exec.sv
// Function
// RQ1: breakpoint enters debug state; immediate ignored
// RQ2: breakpoint executes even when if-then condition fails
// RQ3: mask_clear_form clears, mask_set_form sets selected i/f masks
// RQ4: unprivileged change_processor_state changes nothing
// RQ5: data_memory_barrier orders earlier accesses before later ones
// RQ6: data_memory_barrier does not stall non-memory instructions
// RQ7: nothing after data_sync_barrier executes until it completes
// RQ8: data_sync_barrier completes when all earlier accesses complete
// RQ9: instruction_sync_barrier flushes pipeline for refetch
// RQ10: move_from_special_reg copies selected special register out
// RQ11: reading floor alias returns priority floor value
// RQ12: privileged writes any special register; unprivileged only status flags (code ignores MSR to MSP and PSP)
// RQ13: unprivileged status writes ignore unallocated and execution bits
// RQ14: alias write takes nonzero source below floor, or any if floor zero
// RQ15: status write updates flags from source; others leave flags
// RQ16: no_operation has no architectural effect
// RQ17: send_event signals all processors and sets local event register
// RQ18: supervisor_call raises exception; immediate ignored
// RQ19: wait_for_event with event clear sleeps until one of four wakes
// RQ20: wait_for_event with event set clears it and continues
// RQ21: wait_for_interrupt sleeps until exception or any debug request
// RQ22: other instructions in this block leave flags unchanged
// RQ23: local event register is one bit reset to zero
`timescale 1ns/1ns
`default_nettype none

`include "mse_params.svh"

module mse_exec
    import mse_pkg::*;
#(
    parameter int FW = `MSE_FLOOR_W
) (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          resetn,
    // decoded instruction
    input  wire logic          instr_valid,
    input  wire mse_op_e       instr_op,
    input  wire logic          cond_pass,
    input  wire logic          in_it_block,
    input  wire logic          privileged,
    input  wire logic          cps_sel_i,
    input  wire logic          cps_sel_f,
    input  wire logic [3:0]    spec_sel,
    input  wire logic [31:0]   src_value,
    input  wire logic [7:0]    imm8,
    output var  logic          instr_ready,
    // memory system
    input  wire logic          mem_idle,
    input  wire logic          next_is_mem,
    output var  logic          mem_hold,
    // general register result
    output logic               rd_we,
    output logic [31:0]        rd_data,
    // core state views
    input  wire logic [31:0]   msp_value,
    input  wire logic [31:0]   psp_value,
    output logic [31:0]        psr_value,
    output logic               interrupt_priority_mask_value,
    output logic               fault_mask_a_value,
    output logic [FW-1:0]      floor_value,
    output logic [`MSE_CTRL_W-1:0] control_value,
    // exception and debug
    input  wire logic          exc_unmasked,
    input  wire logic          exc_any,
    input  wire logic          exc_new_pending,
    input  wire logic          wake_on_pending,
    input  wire logic          debug_req,
    input  wire logic          debug_en,
    input  wire logic          ext_event_pin,
    output logic               debug_enter,
    output logic               svc_raise,
    output logic               pipe_flush,
    output logic               event_out,
    output logic               sleeping,
    output logic               event_reg
);

    mse_state_e    st_ff, nxt_st;
    mse_op_e       pend_ff, nxt_pend;
    logic [31:0]   psr_ff, nxt_psr;
    logic          pm_ff, nxt_pm;
    logic          fm_ff, nxt_fm;
    logic [FW-1:0] fl_ff, nxt_fl;
    logic [`MSE_CTRL_W-1:0] ct_ff, nxt_ct;
    logic          ev_ff, nxt_ev;
    logic          rdwe_ff, nxt_rdwe;
    logic [31:0]   rd_ff, nxt_rd;
    logic          dbg_ff, nxt_dbg;
    logic          svc_ff, nxt_svc;
    logic          fl_ff2, nxt_flush;
    logic          sev_ff, nxt_sev;
    logic          ord_ff, nxt_ord;
    logic          ext_ev;
    logic          fl_take;
    logic          wake_wfe;
    logic          wake_wfi;
    logic          execs;
    logic [31:0]   wmask;

    // pin comes from outside the clock domain
    mse_sync u_ev_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .din    (ext_event_pin),
        .dout   (ext_ev)
    );

    // RQ14 floor compare
    mse_floor_upd #(.W(FW)) u_floor (
        .cur  (fl_ff),
        .src  (src_value[FW-1:0]),
        .take (fl_take)
    );

    // RQ19 four wake sources
    assign wake_wfe = exc_unmasked | (exc_new_pending & wake_on_pending)
                    | (debug_req & debug_en) | ext_ev;
    // RQ21 debug wakes regardless
    assign wake_wfi = exc_any | debug_req;

    // RQ7 hold issue until done
    assign instr_ready = (st_ff == MSE_ST_RUN);
    // RQ6 only memory ops are held; issue stays open
    assign mem_hold    = ord_ff && next_is_mem;

    always_comb begin
        nxt_st    = st_ff;
        nxt_pend  = pend_ff;
        // RQ22 flags held
        nxt_psr   = psr_ff;
        nxt_pm    = pm_ff;
        nxt_fm    = fm_ff;
        nxt_fl    = fl_ff;
        nxt_ct    = ct_ff;
        nxt_ev    = ev_ff;
        nxt_rdwe  = 1'b0;
        nxt_rd    = rd_ff;
        nxt_dbg   = 1'b0;
        nxt_svc   = 1'b0;
        nxt_flush = 1'b0;
        nxt_sev   = 1'b0;
        nxt_ord   = ord_ff && !mem_idle;
        // RQ2 breakpoint ignores condition inside it block
        execs = instr_valid && instr_ready
              && (cond_pass || (instr_op == MSE_OP_BREAKPOINT_INSTR && in_it_block));
        // RQ13 unprivileged writes reach only flag bits
        wmask = privileged ? ~`MSE_IPSR_MASK : `MSE_APPLICATION_STATUS_REG_MASK;
        unique case (st_ff)
            MSE_ST_RUN: begin
                if (execs) begin
                    unique case (instr_op)
                        // RQ1 debug entry
                        MSE_OP_BREAKPOINT_INSTR: nxt_dbg = 1'b1;
                        MSE_OP_CPS: begin
                            // RQ4 privilege gate
                            if (privileged) begin
                                // RQ3 ie clears, id sets
                                if (cps_sel_i)
                                    nxt_pm = imm8[0];
                                if (cps_sel_f)
                                    nxt_fm = imm8[0];
                            end
                        end
                        // RQ5 hold later accesses
                        // set wins over the same-cycle idle clear
                        MSE_OP_DMB: nxt_ord = 1'b1;
                        // RQ8 complete on drain
                        MSE_OP_DSB: begin
                            nxt_st   = MSE_ST_DRAIN;
                            nxt_pend = MSE_OP_DSB;
                        end
                        // RQ9 flush
                        MSE_OP_ISB: nxt_flush = 1'b1;
                        MSE_OP_MRS: begin
                            // RQ10 read select
                            nxt_rdwe = 1'b1;
                            unique case (spec_sel)
                                `MSE_SEL_APPLICATION_STATUS_REG:
                                    nxt_rd = psr_ff & `MSE_APPLICATION_STATUS_REG_MASK;
                                `MSE_SEL_IPSR:
                                    nxt_rd = psr_ff & `MSE_IPSR_MASK;
                                `MSE_SEL_EPSR:
                                    nxt_rd = psr_ff & `MSE_EXEC_MASK;
                                `MSE_SEL_IEPSR:
                                    nxt_rd = psr_ff & (`MSE_IPSR_MASK
                                           | `MSE_EXEC_MASK);
                                `MSE_SEL_IAPSR:
                                    nxt_rd = psr_ff & (`MSE_IPSR_MASK
                                           | `MSE_APPLICATION_STATUS_REG_MASK);
                                `MSE_SEL_EAPSR:
                                    nxt_rd = psr_ff & (`MSE_EXEC_MASK
                                           | `MSE_APPLICATION_STATUS_REG_MASK);
                                `MSE_SEL_PSR:   nxt_rd = psr_ff;
                                `MSE_SEL_MSP:   nxt_rd = msp_value;
                                `MSE_SEL_PSP:   nxt_rd = psp_value;
                                `MSE_SEL_PRIMSK:
                                    nxt_rd = {31'h0, pm_ff};
                                // RQ11 alias reads floor
                                `MSE_SEL_FLOOR, `MSE_SEL_FLOOR_CA:
                                    nxt_rd = {{(32-FW){1'b0}}, fl_ff};
                                `MSE_SEL_FAULTMSK:
                                    nxt_rd = {31'h0, fm_ff};
                                `MSE_SEL_CONTROL:
                                    nxt_rd = {30'h0, ct_ff};
                                default: nxt_rd = 32'h0;
                            endcase
                        end
                        MSE_OP_MSR: begin
                            // RQ12 privileged writes all but MSP, PSP and ipsr bits; unprivileged status flags
                            unique case (spec_sel)
                                `MSE_SEL_APPLICATION_STATUS_REG, `MSE_SEL_IPSR,
                                `MSE_SEL_EPSR, `MSE_SEL_IEPSR,
                                `MSE_SEL_IAPSR, `MSE_SEL_EAPSR,
                                `MSE_SEL_PSR:
                                    // RQ15 flags from source
                                    nxt_psr = (psr_ff & ~wmask)
                                            | (src_value & wmask);
                                `MSE_SEL_PRIMSK:
                                    if (privileged) nxt_pm = src_value[0];
                                `MSE_SEL_FLOOR:
                                    if (privileged)
                                        nxt_fl = src_value[FW-1:0];
                                `MSE_SEL_FLOOR_CA:
                                    // RQ14 conditional update
                                    if (privileged && fl_take)
                                        nxt_fl = src_value[FW-1:0];
                                `MSE_SEL_FAULTMSK:
                                    if (privileged) nxt_fm = src_value[0];
                                `MSE_SEL_CONTROL:
                                    if (privileged)
                                        nxt_ct = src_value[`MSE_CTRL_W-1:0];
                                default: ;
                            endcase
                        end
                        // RQ16 no effect
                        MSE_OP_NOP: ;
                        // RQ17 broadcast and set event
                        MSE_OP_SEV: begin
                            nxt_sev = 1'b1;
                            nxt_ev  = 1'b1;
                        end
                        // RQ18 exception, immediate unused
                        MSE_OP_SVC: nxt_svc = 1'b1;
                        MSE_OP_WFE: begin
                            // RQ20 consume event
                            if (ev_ff)
                                nxt_ev = 1'b0;
                            else begin
                                // RQ19 suspend
                                nxt_st   = MSE_ST_SLEEP;
                                nxt_pend = MSE_OP_WFE;
                            end
                        end
                        // RQ21 suspend
                        MSE_OP_WFI: begin
                            nxt_st   = MSE_ST_SLEEP;
                            nxt_pend = MSE_OP_WFI;
                        end
                        default: ;
                    endcase
                end
            end
            MSE_ST_DRAIN: begin
                // RQ8 wait for memory idle
                if (mem_idle)
                    nxt_st = MSE_ST_RUN;
            end
            MSE_ST_SLEEP: begin
                // wake taken as event consumed so a later wfe sleeps
                if ((pend_ff == MSE_OP_WFE) ? wake_wfe : wake_wfi)
                    nxt_st = MSE_ST_RUN;
            end
            default: nxt_st = MSE_ST_RUN;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_ff   <= MSE_ST_RUN;
            pend_ff <= MSE_OP_NONE;
            psr_ff  <= `MSE_PSR_RST;
            pm_ff   <= 1'b0;
            fm_ff   <= 1'b0;
            fl_ff   <= '0;
            ct_ff   <= '0;
            // RQ23 event clear at reset
            ev_ff   <= 1'b0;
            rdwe_ff <= 1'b0;
            rd_ff   <= 32'h0;
            dbg_ff  <= 1'b0;
            svc_ff  <= 1'b0;
            fl_ff2  <= 1'b0;
            sev_ff  <= 1'b0;
            ord_ff  <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            pend_ff <= nxt_pend;
            psr_ff  <= nxt_psr;
            pm_ff   <= nxt_pm;
            fm_ff   <= nxt_fm;
            fl_ff   <= nxt_fl;
            ct_ff   <= nxt_ct;
            ev_ff   <= nxt_ev;
            rdwe_ff <= nxt_rdwe;
            rd_ff   <= nxt_rd;
            dbg_ff  <= nxt_dbg;
            svc_ff  <= nxt_svc;
            fl_ff2  <= nxt_flush;
            sev_ff  <= nxt_sev;
            ord_ff  <= nxt_ord;
        end
    end

    assign rd_we           = rdwe_ff;
    assign rd_data         = rd_ff;
    assign psr_value       = psr_ff;
    assign interrupt_priority_mask_value   = pm_ff;
    assign fault_mask_a_value = fm_ff;
    assign floor_value     = fl_ff;
    assign control_value   = ct_ff;
    assign debug_enter     = dbg_ff;
    assign svc_raise       = svc_ff;
    assign pipe_flush      = fl_ff2;
    assign event_out       = sev_ff;
    assign sleeping        = (st_ff == MSE_ST_SLEEP);
    assign event_reg       = ev_ff;

    // RQ1 breakpoint then debug entry
    property p_breakpoint_instr_dbg;
        @(posedge mclk) disable iff (!resetn)
        (execs && instr_op == MSE_OP_BREAKPOINT_INSTR) |=> debug_enter;
    endproperty
    a_breakpoint_instr_dbg: assert property (p_breakpoint_instr_dbg) // RQ1
        else $error("breakpoint did not enter debug");

    // RQ4 unprivileged cps no mask change
    property p_cps_unpriv;
        @(posedge mclk) disable iff (!resetn)
        (execs && instr_op == MSE_OP_CPS && !privileged)
        |=> $stable(interrupt_priority_mask_value) && $stable(fault_mask_a_value);
    endproperty
    a_cps_unpriv: assert property (p_cps_unpriv) // RQ4
        else $error("unprivileged cps changed a mask");

    // RQ7 no issue while draining
    property p_dsb_hold;
        @(posedge mclk) disable iff (!resetn)
        (execs && instr_op == MSE_OP_DSB) |=> !instr_ready;
    endproperty
    a_dsb_hold: assert property (p_dsb_hold) // RQ7
        else $error("issue allowed after sync barrier");

    // RQ8 completes only with memory idle
    property p_dsb_done;
        @(posedge mclk) disable iff (!resetn)
        (st_ff == MSE_ST_DRAIN && !mem_idle) |=> !instr_ready;
    endproperty
    a_dsb_done: assert property (p_dsb_done) // RQ8
        else $error("barrier completed with memory busy");

    // RQ9 flush follows barrier
    property p_isb_flush;
        @(posedge mclk) disable iff (!resetn)
        (execs && instr_op == MSE_OP_ISB) |=> pipe_flush ##1 !pipe_flush;
    endproperty
    a_isb_flush: assert property (p_isb_flush) // RQ9
        else $error("isb flush missing or stretched");

    // RQ11 alias reads floor
    property p_alias_rd;
        @(posedge mclk) disable iff (!resetn)
        (execs && instr_op == MSE_OP_MRS && spec_sel == `MSE_SEL_FLOOR_CA)
        |=> rd_we && rd_data[FW-1:0] == $past(floor_value);
    endproperty
    a_alias_rd: assert property (p_alias_rd) // RQ11
        else $error("alias read differs from floor");

    // RQ17 send_event sets event
    property p_sev;
        @(posedge mclk) disable iff (!resetn)
        (execs && instr_op == MSE_OP_SEV) |=> event_reg && event_out;
    endproperty
    a_sev: assert property (p_sev) // RQ17
        else $error("send_event did not set event");

    // RQ20 event set: no sleep, cleared
    property p_wfe_skip;
        @(posedge mclk) disable iff (!resetn)
        (execs && instr_op == MSE_OP_WFE && event_reg)
        |=> !event_reg && !sleeping;
    endproperty
    a_wfe_skip: assert property (p_wfe_skip) // RQ20
        else $error("wfe with event set slept");

    // RQ21 debug request wakes wfi
    property p_wfi_wake;
        @(posedge mclk) disable iff (!resetn)
        (sleeping && pend_ff == MSE_OP_WFI && debug_req) |=> !sleeping;
    endproperty
    a_wfi_wake: assert property (p_wfi_wake) // RQ21
        else $error("debug request did not wake wfi");

endmodule : mse_exec

`default_nettype wire

// ### mse_mem_model.sv
`timescale 1ns/1ns
`default_nettype none

// far-side memory: a launch leaves a burst of explicit accesses outstanding
module mse_mem_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // request side
    input  wire logic       launch,
    input  wire logic [3:0] burst,
    input  wire logic       mem_hold,
    // status
    output var  logic       mem_idle
);
    logic [4:0] left_ff;

    assign mem_idle = (left_ff == 5'h00);

    // launch refused while held, so later accesses wait for earlier ones
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            left_ff <= 5'h00;
        end else if (launch && !mem_hold) begin
            left_ff <= {1'b0, burst} + 5'h01;
        end else if (left_ff != 5'h00) begin
            left_ff <= left_ff - 5'h01;
        end
    end
endmodule : mse_mem_model

`default_nettype wire

// ### misc_system_instruction_exec_tb.sv
`timescale 1ns/1ns
`default_nettype none

`include "mse_params.svh"

module misc_system_instruction_exec_tb
    import mse_pkg::*;
;
    logic mclk = 0, resetn = 0, instr_valid = 0, cond_pass = 1;
    logic in_it_block = 0, privileged = 1, cps_sel_i = 0, cps_sel_f = 0;
    logic next_is_mem = 0, exc_unmasked = 0, exc_any = 0, debug_req = 0;
    logic exc_new_pending = 0, wake_on_pending = 0, debug_en = 0;
    logic ext_event_pin = 0, launch = 0, mem_idle;
    logic [3:0]  spec_sel = 4'h0, burst = 4'h0;
    logic [31:0] src_value = 32'h0, msp_value = 32'h0, psp_value = 32'h0;
    logic [7:0]  imm8 = 8'h00;
    mse_op_e     instr_op = MSE_OP_NONE;
    logic instr_ready, mem_hold, rd_we, interrupt_priority_mask_value, fault_mask_a_value;
    logic debug_enter, svc_raise, pipe_flush, event_out, sleeping, event_reg;
    logic [31:0] rd_data, psr_value;
    logic [7:0]  floor_value;
    logic [1:0]  control_value;
    int fail_count = 0, comparisons = 0, cycles = 0, m_pm = 0, m_fm = 0;
    int m_floor = 0, v;
    logic [31:0] m_psr = `MSE_PSR_RST;

    mse_exec i_dut (.mclk(mclk), .resetn(resetn), .instr_valid(instr_valid),
        .instr_op(instr_op), .cond_pass(cond_pass), .in_it_block(in_it_block),
        .privileged(privileged), .cps_sel_i(cps_sel_i),
        .cps_sel_f(cps_sel_f), .spec_sel(spec_sel), .src_value(src_value),
        .imm8(imm8), .instr_ready(instr_ready), .mem_idle(mem_idle),
        .next_is_mem(next_is_mem), .mem_hold(mem_hold), .rd_we(rd_we),
        .rd_data(rd_data), .msp_value(msp_value), .psp_value(psp_value),
        .psr_value(psr_value), .interrupt_priority_mask_value(interrupt_priority_mask_value),
        .fault_mask_a_value(fault_mask_a_value), .floor_value(floor_value),
        .control_value(control_value), .exc_unmasked(exc_unmasked),
        .exc_any(exc_any), .exc_new_pending(exc_new_pending),
        .wake_on_pending(wake_on_pending), .debug_req(debug_req),
        .debug_en(debug_en), .ext_event_pin(ext_event_pin),
        .debug_enter(debug_enter), .svc_raise(svc_raise),
        .pipe_flush(pipe_flush), .event_out(event_out),
        .sleeping(sleeping), .event_reg(event_reg));

    mse_mem_model i_mem (.mclk(mclk), .resetn(resetn), .launch(launch),
        .burst(burst), .mem_hold(mem_hold), .mem_idle(mem_idle));

    always #4 mclk = ~mclk;

    task automatic test_done();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_b(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t flag got %b exp %b", $time, got, exp);
        end
    endtask : chk_b

    // holds the request until ready, leaves 1 ns after the taking edge
    task automatic issue(input mse_op_e op, input logic [3:0] sel,
                         input logic [31:0] src, input logic [7:0] imm);
        int n;
        n = 0;
        @(posedge mclk);
        #1;
        instr_valid = 1'b1;
        instr_op    = op;
        spec_sel    = sel;
        src_value   = src;
        imm8        = imm;
        while (instr_ready !== 1'b1 && n < 200) begin
            @(posedge mclk);
            #1;
            n++;
        end
        @(posedge mclk);
        #1;
        instr_valid = 1'b0;
        chk_w(psr_value, m_psr);
    endtask : issue

    task automatic wait_until(input int which);
        int n;
        n = 0;
        while ((which ? !instr_ready : sleeping) === 1'b1 && n < 60) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask : wait_until

    task automatic go_mem(input logic [3:0] b);
        @(posedge mclk);
        #1;
        launch = 1'b1;
        burst  = b;
        @(posedge mclk);
        #1;
        launch = 1'b0;
    endtask : go_mem

    initial begin
        void'($urandom(4029));
        repeat (16) @(posedge mclk);
        #1;
        resetn = 1'b1;
        chk_b(event_reg, 1'b0);
        in_it_block = 1'b1;
        cond_pass   = 1'b0;
        issue(MSE_OP_BREAKPOINT_INSTR, 4'h0, 32'h0, 8'($urandom));
        chk_b(debug_enter, 1'b1);
        {in_it_block, cond_pass} = 2'b01;
        issue(MSE_OP_SVC, 4'h0, 32'h0, 8'($urandom));
        chk_b(svc_raise, 1'b1);
        issue(MSE_OP_ISB, 4'h0, 32'h0, 8'h00);
        chk_b(pipe_flush, 1'b1);
        issue(MSE_OP_NOP, 4'h0, 32'h0, 8'h00);
        chk_b(rd_we, 1'b0);
        issue(MSE_OP_SEV, 4'h0, 32'h0, 8'h00);
        chk_b(event_out, 1'b1);
        chk_b(event_reg, 1'b1);
        issue(MSE_OP_WFE, 4'h0, 32'h0, 8'h00);
        chk_b(sleeping, 1'b0);
        chk_b(event_reg, 1'b0);
        for (int k = 0; k < 4; k++) begin
            issue(MSE_OP_WFE, 4'h0, 32'h0, 8'h00);
            chk_b(sleeping, 1'b1);
            exc_unmasked    = (k == 0);
            exc_new_pending = (k == 1);
            wake_on_pending = (k == 1);
            debug_req       = (k == 2);
            debug_en        = (k == 2);
            ext_event_pin   = (k == 3);
            wait_until(0);
            chk_b(sleeping, 1'b0);
            {exc_unmasked, exc_new_pending, wake_on_pending} = 3'h0;
            {debug_req, debug_en, ext_event_pin} = 3'h0;
        end
        issue(MSE_OP_WFI, 4'h0, 32'h0, 8'h00);
        chk_b(sleeping, 1'b1);
        debug_req = 1'b1;
        wait_until(0);
        chk_b(sleeping, 1'b0);
        debug_req = 1'b0;
        for (int k = 0; k < 16; k++) begin
            privileged = ~k[3];
            cps_sel_i  = k[1];
            cps_sel_f  = k[0];
            if (!k[3] && k[1]) m_pm = k[2];
            if (!k[3] && k[0]) m_fm = k[2];
            issue(MSE_OP_CPS, 4'h0, 32'h0, {7'h00, k[2]});
            chk_b(interrupt_priority_mask_value, m_pm[0]);
            chk_b(fault_mask_a_value, m_fm[0]);
        end
        privileged = 1'b1;
        issue(MSE_OP_MSR, `MSE_SEL_FLOOR, 32'h0, 8'h00);
        for (int k = 0; k < 24; k++) begin
            v = (k == 0) ? 0 : int'($urandom % 48);
            if (v != 0 && (m_floor == 0 || v < m_floor)) m_floor = v;
            issue(MSE_OP_MSR, `MSE_SEL_FLOOR_CA, 32'(v), 8'h00);
            issue(MSE_OP_MRS, `MSE_SEL_FLOOR_CA, 32'h0, 8'h00);
            chk_w(rd_data, 32'(m_floor));
            chk_w(32'(floor_value), 32'(m_floor));
        end
        msp_value = $urandom;
        issue(MSE_OP_MRS, `MSE_SEL_MSP, 32'h0, 8'h00);
        chk_b(rd_we, 1'b1);
        chk_w(rd_data, msp_value);
        issue(MSE_OP_MSR, `MSE_SEL_CONTROL, 32'h3, 8'h00);
        chk_w(32'(control_value), 32'h3);
        privileged = 1'b0;
        issue(MSE_OP_MSR, `MSE_SEL_PRIMSK, 32'h0, 8'h00);
        chk_b(interrupt_priority_mask_value, m_pm[0]);
        v = $urandom;
        m_psr = (m_psr & ~`MSE_APPLICATION_STATUS_REG_MASK) | (32'(v) & `MSE_APPLICATION_STATUS_REG_MASK);
        issue(MSE_OP_MSR, `MSE_SEL_APPLICATION_STATUS_REG, 32'(v), 8'h00);
        go_mem(4'h9);
        issue(MSE_OP_DSB, 4'h0, 32'h0, 8'h00);
        chk_b(instr_ready, 1'b0);
        wait_until(1);
        chk_b(mem_idle, 1'b1);
        go_mem(4'h6);
        next_is_mem = 1'b1;
        issue(MSE_OP_DMB, 4'h0, 32'h0, 8'h00);
        chk_b(mem_hold, 1'b1);
        chk_b(instr_ready, 1'b1);
        issue(MSE_OP_NOP, 4'h0, 32'h0, 8'h00);
        chk_b(mem_hold, 1'b1);
        repeat (8) @(posedge mclk);
        #1;
        chk_b(mem_hold, 1'b0);
        wait_until(1);
        next_is_mem = 1'b0;
        test_done();
    end
endmodule : misc_system_instruction_exec_tb

`default_nettype wire
